// ===== bench/dpsf_frontend_test.sv
// Self-checking bench: host model sends frames, a monitor checks results
`timescale 1ns/1ns
module dpsf_frontend_test;
   import dpsf_pkg::*;
   // Short store so a full run stays brief
   localparam int SC = 400;
   typedef struct packed {
      logic        isRead;
      logic [15:0] val;
   } dpsf_note_t;

   logic                 clk = 1'b0;
   logic                 reset;
   logic                 serialClk, frameSyncN, serialDataIn;
   logic                 serialDataOut, serialDataOutOe, opDone, opDoneOe;
   logic [DATA_BITS-1:0] wiperSetting;
   logic [CTRL_BITS-1:0] controlBits;
   logic                 shutdown;
   logic [15:0]          rxWord, prevRegs, regModel, hold;
   logic [9:0]           a;
   dpsf_note_t           q[$];
   int                   err_count = 0;
   int                   n_checks = 0;
   int                   seed = 13756;
   int                   waitN;
   event                 rxSeen;

   // *****
   // Clock, design and host model
   // *****
   always #2 clk = ~clk;

   dpsf_frontend #(.STORE_COUNT(SC)) dpsf_frontend_i (
      .clk(clk), .reset(reset), .serialClk(serialClk),
      .frameSyncN(frameSyncN), .serialDataIn(serialDataIn),
      .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe),
      .opDone(opDone), .opDoneOe(opDoneOe), .wiperSetting(wiperSetting),
      .controlBits(controlBits), .shutdown(shutdown));

   dpsf_host_model dpsf_host_model_i (
      .serialClk(serialClk), .frameSyncN(frameSyncN),
      .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .serialDataOutOe(serialDataOutOe));

   // *****
   // Checking and notes
   // *****
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // Oldest note must match; a change with no note is an error
   task automatic take(input logic rd, input logic [15:0] seen);
      dpsf_note_t n;
      if (q.size() > 0 && q[0].isRead === rd) begin
         n = q.pop_front();
         check(rd ? "readback" : "registers", seen, n.val);
      end else if (!rd) begin
         check("spurious change", seen, prevRegs);
      end
   endtask : take

   task automatic pushReg(input logic [15:0] v);
      if (v !== regModel) begin
         q.push_back({1'b0, v});
      end
      regModel = v;
   endtask : pushReg

   task automatic pushRead(input logic [15:0] v);
      q.push_back({1'b1, v});
   endtask : pushRead

   // Gap after each frame lets decode finish before the next one
   task automatic xfer(input logic [31:0] w, input int n);
      dpsf_host_model_i.send(w, n, hold);
      rxWord = hold;
      ->rxSeen;
      repeat (12) @(posedge clk);
   endtask : xfer

   task automatic cmd(input logic [3:0] c, input logic [9:0] d);
      xfer({18'h00000, c, d}, 16);
   endtask : cmd

   // Register monitor: packs shutdown, control and wiper
   always @(posedge clk) begin
      if (!reset && {1'b0, shutdown, controlBits, wiperSetting} !== prevRegs)
      begin
         take(1'b0, {1'b0, shutdown, controlBits, wiperSetting});
      end
      prevRegs <= {1'b0, shutdown, controlBits, wiperSetting};
   end

   always @(rxSeen) take(1'b1, rxWord);

   // *****
   // Main sequence
   // *****
   initial begin
      // Rising reset at time zero so the link flops see their clear
      reset <= 1'b1;
      regModel = {2'b00, CTRL_RESET, WIPER_RESET};
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      check("reset regs",
            {1'b0, shutdown, controlBits, wiperSetting}, regModel);
      check("reset ready", {14'h0, opDone, opDoneOe}, 16'h0000);
      pushReg({regModel[15:10], 10'h155});
      cmd(CMD_WR_WIPER, 10'h155);
      for (int i = 0; i < 4; i++) begin
         a = $random(seed);
         pushReg({regModel[15:10], a});
         cmd(CMD_WR_WIPER, a);
      end
      // Readback shows up during the following frame
      cmd(CMD_RD_WIPER, 10'h000);
      pushRead({5'h00, regModel[9:0], 1'b0});
      cmd(CMD_NOP, 10'h3FF);
      pushReg({regModel[15:14], 4'hA, regModel[9:0]});
      cmd(CMD_WR_CTRL, 10'h3FA);
      cmd(CMD_RD_CTRL, 10'h000);
      pushRead({11'h000, 4'hA, 1'b0});
      cmd(CMD_NOP, 10'h000);
      pushReg({2'b01, regModel[13:0]});
      cmd(CMD_SHUTDOWN, 10'h001);
      pushReg({2'b00, regModel[13:0]});
      cmd(CMD_SHUTDOWN, 10'h3FE);
      // Short, odd and bad-pad words must leave everything alone
      xfer({18'h00000, CMD_WR_WIPER, 10'h0AA} >> 1, 15);
      xfer({17'h00000, CMD_WR_WIPER, 10'h0AA, 1'b1}, 17);
      xfer({16'h0000, 2'b01, CMD_WR_WIPER, 10'h0AA}, 16);
      // Daisy chain: first word passes on, last word is taken
      a = $random(seed);
      // Register change lands after frame sync rises but before the readback is taken, so its note goes first
      pushReg({regModel[15:10], a});
      pushRead({1'b0, CMD_WR_CTRL, 10'h155, 1'b0});
      xfer({2'b00, CMD_WR_CTRL, 10'h155, 2'b00, CMD_WR_WIPER, a}, 32);
      // Store, then a write that the busy store must drop
      cmd(CMD_STORE_FUSE, 10'h000);
      cmd(CMD_WR_WIPER, ~a);
      check("busy in store", {14'h0, opDone, opDoneOe}, 16'h0001);
      waitN = 0;
      while (opDoneOe !== 1'b0) begin
         @(posedge clk);
         waitN++;
         if (waitN > 1000) begin
            err_count++;
            give_verdict();
         end
      end
      pushReg({regModel[15:10], ~a});
      cmd(CMD_WR_WIPER, ~a);
      pushReg({regModel[15:10], a});
      cmd(CMD_REFRESH, 10'h000);
      cmd(CMD_RD_FUSE, 10'h000);
      pushRead(16'h0002);
      cmd(CMD_RD_FUSE, 10'h001);
      pushRead({5'h00, a, 1'b0});
      cmd(CMD_NOP, 10'h000);
      check("idle ready", {14'h0, opDone, opDoneOe}, 16'h0000);
      waitN = 0;
      while (q.size() > 0) begin
         @(posedge clk);
         waitN++;
         if (waitN > 100) begin
            err_count++;
            give_verdict();
         end
      end
      give_verdict();
   end
endmodule : dpsf_frontend_test

// ===== bench/dpsf_host_model.sv
// Behavioural host controller that drives the serial link
`timescale 1ns/1ns
module dpsf_host_model (
   output logic      serialClk,
   output logic      frameSyncN,
   output logic      serialDataIn,
   input  wire logic serialDataOut,
   input  wire logic serialDataOutOe
);
   logic sdoLine;

   // Open-drain line with pull-up: a released line reads high
   assign sdoLine = serialDataOutOe ? serialDataOut : 1'b1;

   // Idle: clock parked high, frame sync inactive
   initial begin
      serialClk = 1'b1;
      frameSyncN = 1'b1;
      serialDataIn = 1'b1;
   end

   // One frame of n bits; 64 ns bit time keeps the link below its limit
   task automatic send(input logic [31:0] w, input int n,
                       output logic [15:0] rx);
      rx = 16'h0000;
      #3 frameSyncN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serialDataIn = w[i];
         #32 serialClk = 1'b0;
         #31 rx = {rx[14:0], sdoLine};
         #1 serialClk = 1'b1;
      end
      #32 frameSyncN = 1'b1;
      // Stale data would hide a late sample, so flip it
      serialDataIn = ~serialDataIn;
      #40;
   endtask : send
endmodule : dpsf_host_model

// ===== logic/dpsf_fifo.sv
// Synchronous word FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dpsf_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   // Refuse depths the pointer logic cannot serve
   if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("dpsf_fifo: DEPTH must be >= 2 and WIDTH >= 1");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [CW-1:0]               count;
   } dpsf_fifo_st_t;

   dpsf_fifo_st_t st_q;
   dpsf_fifo_st_t st_d;
   logic          push;
   logic          pop;

   assign inReady  = (st_q.count != FULL);
   assign outValid = (st_q.count != '0);
   assign outData  = st_q.mem[st_q.rp];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // ************************************************************
   // Pointer and count update
   // ************************************************************
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.mem[st_q.wp] = inData;
         st_d.wp = (st_q.wp == LAST) ? '0 : st_q.wp + 1'b1;
      end
      if (pop) begin
         st_d.rp = (st_q.rp == LAST) ? '0 : st_q.rp + 1'b1;
      end
      if (push && !pop) begin
         st_d.count = st_q.count + 1'b1;
      end else if (pop && !push) begin
         st_d.count = st_q.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule : dpsf_fifo

// ===== logic/dpsf_frontend.sv
// Serial front end of a single-channel digital potentiometer
// What this block does
// - Sixteen-bit shift register receives every serial input word.
// - Data sampled and shifted on each serial clock falling edge in frame.
// - Frame starts with frame sync low; shifting enabled only while low.
// - Selected register updates on frame sync rise after sixteenth edge.
// - Early frame sync rise aborts; partial word discarded, nothing changes.
// - Serial data out is open drain: pull low or release only.
// - Serial data out shows shift register, for daisy chain and readback.
// - Ready output, open drain, signals completed operation.
// - Words MSB first: two zeros, four command bits, ten data bits.
// - Commands 0..8 decoded: nop, wiper, reads, fuse, control, shutdown.
// - Frames accepted only in whole multiples of sixteen edges.
// - Fuse store of about 6 ms drops words framed meanwhile; ready shows end.
`timescale 1ns/1ns
module dpsf_frontend
   import dpsf_pkg::*;
#(
   parameter int STORE_COUNT = STORE_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 serialClk,
   input  wire logic                 frameSyncN,
   input  wire logic                 serialDataIn,
   output logic                      serialDataOut,
   output logic                      serialDataOutOe,
   output logic                      opDone,
   output logic                      opDoneOe,
   output logic      [DATA_BITS-1:0] wiperSetting,
   output logic      [CTRL_BITS-1:0] controlBits,
   output logic                      shutdown
);
   localparam int TW = $clog2(STORE_COUNT + 1);
   localparam logic [TW-1:0] STORE_LAST = TW'(STORE_COUNT - 1);

   // Store time must be at least one cycle
   if (STORE_COUNT < 1) begin : g_bad
      $error("dpsf_frontend: STORE_COUNT must be >= 1");
   end

   // ************************************************************
   // Link domain state (falls of serialClk)
   // ************************************************************
   typedef struct packed {
      logic [WORD_BITS-1:0] shift;
      logic [3:0]           cnt;
      logic                 got16;
      logic                 frameTog;
      logic                 sdoOe;
   } dpsf_link_st_t;

   // ************************************************************
   // Core domain state
   // ************************************************************
   typedef struct packed {
      logic                 fsPrev;
      logic                 seenTog;
      dpsf_state_t          state;
      logic [TW-1:0]        timer;
      logic [DATA_BITS-1:0] wiper;
      logic [CTRL_BITS-1:0] ctrl;
      logic                 shut;
      logic [DATA_BITS-1:0] fuseVal;
      logic [SLOT_BITS-1:0] fuseCnt;
      logic [WORD_BITS-1:0] readWord;
      logic                 readPend;
      logic                 rdyOe;
   } dpsf_core_st_t;

   dpsf_link_st_t        lk_q;
   dpsf_link_st_t        lk_d;
   dpsf_core_st_t        c_q;
   dpsf_core_st_t        c_d;
   logic                 armedQ;
   logic                 fsLevel;
   logic                 frameRise;
   logic                 newFrame;
   logic                 wordOk;
   logic                 pushValid;
   logic                 fifoInReady;
   logic                 fifoOutValid;
   logic                 fifoOutReady;
   logic [WORD_BITS-1:0] fifoOutData;
   logic                 popWord;
   dpsf_cmd_t            popCmd;
   logic [DATA_BITS-1:0] popData;

   // ************************************************************
   // Link side: shift register on serialClk falls
   // ************************************************************
   // Armed by reset and while frame sync is high; first fall clears it.
   // Without the reset term the first frame after power-up could be lost
   always_ff @(negedge serialClk or posedge frameSyncN or posedge reset) begin
      if (reset || frameSyncN) begin
         armedQ <= 1'b1;
      end else begin
         armedQ <= 1'b0;
      end
   end

   // Readback word is loaded on the first fall; the core keeps it
   // still between frames, so the quasi-static read is safe
   always_comb begin
      lk_d = lk_q;
      if (!frameSyncN) begin
         if (armedQ) begin
            lk_d.frameTog = ~lk_q.frameTog;
            lk_d.cnt      = 4'h1;
            lk_d.got16    = 1'b0;
            if (c_q.readPend) begin
               lk_d.shift = {c_q.readWord[WORD_BITS-2:0], serialDataIn};
            end else begin
               lk_d.shift = {lk_q.shift[WORD_BITS-2:0], serialDataIn};
            end
         end else begin
            lk_d.cnt   = lk_q.cnt + 4'h1;
            lk_d.got16 = lk_q.got16 || (lk_q.cnt == 4'hF);
            lk_d.shift = {lk_q.shift[WORD_BITS-2:0], serialDataIn};
         end
         lk_d.sdoOe = ~lk_d.shift[WORD_BITS-1];
      end
   end

   // Reset clears the link flops too, so frame toggles start equal
   always_ff @(negedge serialClk or posedge reset) begin
      if (reset) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // ************************************************************
   // Frame boundary detection in the core domain
   // ************************************************************
   dpsf_sync #(
      .INIT (1'b1)
   ) u_fs_sync (
      .clk   (clk),
      .reset (reset),
      .din   (frameSyncN),
      .dout  (fsLevel)
   );

   // Link clock is stopped once frame sync is high, so its flops are
   // stable by the time the filtered rise is seen here
   assign frameRise = fsLevel && !c_q.fsPrev;
   assign newFrame  = (lk_q.frameTog != c_q.seenTog);
   assign wordOk    = newFrame && lk_q.got16 && (lk_q.cnt == 4'h0);
   // Locked during a store; a full FIFO refuses the word as well
   assign pushValid = frameRise && wordOk && (c_q.state != ST_STORE)
                      && fifoInReady;

   // ************************************************************
   // Command buffer
   // ************************************************************
   dpsf_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_cmd_fifo (
      .clk      (clk),
      .reset    (reset),
      .inValid  (pushValid),
      .inReady  (fifoInReady),
      .inData   (lk_q.shift),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   assign fifoOutReady = (c_q.state == ST_IDLE);
   assign popWord      = fifoOutValid && fifoOutReady;
   assign popCmd       = dpsf_cmd_t'(fifoOutData[CMD_MSB:CMD_LSB]);
   assign popData      = fifoOutData[DATA_BITS-1:0];

   // ************************************************************
   // Command decoder and fuse store sequencer
   // ************************************************************
   always_comb begin
      c_d        = c_q;
      c_d.fsPrev = fsLevel;
      if (frameRise) begin
         c_d.seenTog = lk_q.frameTog;
      end
      case (c_q.state)
         ST_IDLE: begin
            // Words with nonzero pad bits act as no-ops
            if (popWord && fifoOutData[PAD_MSB:PAD_LSB] == 2'b00) begin
               c_d.readPend = 1'b0;
               case (popCmd)
                  CMD_WR_WIPER: begin
                     c_d.wiper = popData;
                  end
                  CMD_RD_WIPER: begin
                     c_d.readWord = WORD_BITS'(c_q.wiper);
                     c_d.readPend = 1'b1;
                  end
                  CMD_STORE_FUSE: begin
                     // All slots used: store is ignored
                     if (c_q.fuseCnt != FUSE_SLOTS) begin
                        c_d.state = ST_STORE;
                        c_d.timer = STORE_LAST;
                     end
                  end
                  CMD_REFRESH: begin
                     c_d.wiper = c_q.fuseVal;
                  end
                  CMD_RD_FUSE: begin
                     if (popData[SLOT_BITS-1:0] == STATUS_SELECT) begin
                        c_d.readWord = WORD_BITS'(c_q.fuseCnt);
                     end else begin
                        c_d.readWord = WORD_BITS'(c_q.fuseVal);
                     end
                     c_d.readPend = 1'b1;
                  end
                  CMD_WR_CTRL: begin
                     c_d.ctrl = popData[CTRL_BITS-1:0];
                  end
                  CMD_RD_CTRL: begin
                     c_d.readWord = WORD_BITS'(c_q.ctrl);
                     c_d.readPend = 1'b1;
                  end
                  CMD_SHUTDOWN: begin
                     c_d.shut = popData[0];
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_STORE: begin
            if (c_q.timer == '0) begin
               c_d.state   = ST_IDLE;
               c_d.fuseVal = c_q.wiper;
               c_d.fuseCnt = c_q.fuseCnt + 5'h01;
            end else begin
               c_d.timer = c_q.timer - 1'b1;
            end
         end
         default: begin
            c_d.state = ST_IDLE;
         end
      endcase
      // Ready held low while busy, released (high) when done
      c_d.rdyOe = (c_d.state == ST_STORE) || fifoOutValid;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         c_q          <= '0;
         c_q.fsPrev   <= 1'b1;
         c_q.state    <= ST_IDLE;
         c_q.wiper    <= WIPER_RESET;
         c_q.ctrl     <= CTRL_RESET;
         c_q.fuseVal  <= WIPER_RESET;
      end else begin
         c_q <= c_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Open-drain pins only ever drive zero
   assign serialDataOut   = 1'b0;
   assign serialDataOutOe = lk_q.sdoOe;
   assign opDone          = 1'b0;
   assign opDoneOe        = c_q.rdyOe;
   assign wiperSetting    = c_q.wiper;
   assign controlBits     = c_q.ctrl;
   assign shutdown        = c_q.shut;

   // ************************************************************
   // Assertions
   // ************************************************************
   chk_shift_advance: assert property (
      @(negedge serialClk) disable iff (frameSyncN || reset)
      !armedQ |=> lk_q.shift[0] == $past(serialDataIn)
                  && lk_q.shift[WORD_BITS-1:1]
                     == $past(lk_q.shift[WORD_BITS-2:0]))
      else $error("shift register did not advance on serial clock fall");

   chk_shift_width: assert property (
      @(negedge serialClk) disable iff (frameSyncN || reset)
      !armedQ ##1 !armedQ[*8] |->
         lk_q.shift[WORD_BITS-1:8] == $past(lk_q.shift[7:0], 8))
      else $error("shift register does not hold sixteen bits");

   chk_abort_drop: assert property (
      @(posedge clk) disable iff (reset)
      frameRise && !(lk_q.got16 && lk_q.cnt == 4'h0) |-> !pushValid)
      else $error("partial frame was committed");

   chk_commit_push: assert property (
      @(posedge clk) disable iff (reset)
      frameRise && wordOk && c_q.state == ST_IDLE && fifoInReady
      |=> fifoOutValid)
      else $error("complete frame was not committed");

   chk_store_lock: assert property (
      @(posedge clk) disable iff (reset)
      c_q.state == ST_STORE |-> !pushValid && !fifoOutReady)
      else $error("word taken during fuse store");

   chk_store_end: assert property (
      @(posedge clk) disable iff (reset)
      c_q.state == ST_STORE && c_q.timer == '0
      |=> c_q.state == ST_IDLE && c_q.fuseVal == $past(c_q.wiper))
      else $error("fuse store did not finish with wiper value");

   chk_ready_busy: assert property (
      @(posedge clk) disable iff (reset)
      $rose(c_q.state == ST_STORE) |-> opDoneOe ##1 opDoneOe)
      else $error("ready released during fuse store");

   chk_write_wiper: assert property (
      @(posedge clk) disable iff (reset)
      popWord && popCmd == CMD_WR_WIPER
      && fifoOutData[PAD_MSB:PAD_LSB] == 2'b00
      |=> wiperSetting == $past(popData))
      else $error("wiper write not applied");

   chk_pad_ignore: assert property (
      @(posedge clk) disable iff (reset)
      popWord && fifoOutData[PAD_MSB:PAD_LSB] != 2'b00
      |=> $stable(wiperSetting) && $stable(controlBits))
      else $error("word with nonzero pad bits was acted on");

   chk_sdo_drain: assert property (
      @(posedge clk) disable iff (reset)
      serialDataOut == 1'b0)
      else $error("serial data out driven high");

   cov_wiper_write: cover property (
      @(posedge clk) disable iff (reset)
      popWord && popCmd == CMD_WR_WIPER);

   cov_fuse_store: cover property (
      @(posedge clk) disable iff (reset)
      c_q.state == ST_STORE ##1 c_q.state == ST_IDLE);

   cov_abort: cover property (
      @(posedge clk) disable iff (reset)
      frameRise && newFrame && !wordOk);

   cov_readback: cover property (
      @(posedge clk) disable iff (reset)
      c_q.readPend ##1 frameRise && wordOk);

endmodule : dpsf_frontend

// ===== logic/dpsf_pkg.sv
// Shared constants and types for the digipot serial front end
package dpsf_pkg;

   // ************************************************************
   // Word layout
   // ************************************************************
   localparam int WORD_BITS = 16;
   localparam int PAD_MSB   = 15;
   localparam int PAD_LSB   = 14;
   localparam int CMD_MSB   = 13;
   localparam int CMD_LSB   = 10;
   localparam int DATA_BITS = 10;
   localparam int CTRL_BITS = 4;
   localparam int SLOT_BITS = 5;

   // ************************************************************
   // Commands and states
   // ************************************************************
   typedef enum logic [3:0] {
      CMD_NOP        = 4'h0,
      CMD_WR_WIPER   = 4'h1,
      CMD_RD_WIPER   = 4'h2,
      CMD_STORE_FUSE = 4'h3,
      CMD_REFRESH    = 4'h4,
      CMD_RD_FUSE    = 4'h5,
      CMD_WR_CTRL    = 4'h6,
      CMD_RD_CTRL    = 4'h7,
      CMD_SHUTDOWN   = 4'h8
   } dpsf_cmd_t;

   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_STORE = 1'b1
   } dpsf_state_t;

   // ************************************************************
   // Reset values and limits
   // ************************************************************
   localparam logic [9:0] WIPER_RESET   = 10'h200;
   localparam logic [3:0] CTRL_RESET    = 4'h0;
   localparam logic [4:0] FUSE_SLOTS    = 5'h14;
   localparam logic [4:0] STATUS_SELECT = 5'h00;
   localparam int         FIFO_DEPTH    = 16;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 4;
   localparam int LINK_MAX_MHZ   = 50;
   localparam int STORE_TIME_NS  = 6000000;
   localparam int STORE_CYCLES   = STORE_TIME_NS / CLK_PERIOD_NS;

endpackage : dpsf_pkg

// ===== logic/dpsf_sync.sv
// Three-stage synchroniser with agreement filter for one level
`timescale 1ns/1ns
module dpsf_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } dpsf_sync_st_t;

   dpsf_sync_st_t st_q;
   dpsf_sync_st_t st_d;

   // ************************************************************
   // Chain and filter
   // ************************************************************
   // First stage feeds only the second; level moves when 2 and 3 agree
   always_comb begin
      st_d    = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.level = st_q.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '{INIT, INIT, INIT, INIT};
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.level;

endmodule : dpsf_sync
